/* File: logic/exc_consts.vh */
`ifndef EXC_CONSTS_VH
`define EXC_CONSTS_VH

// register byte offsets
`define OFS_EXT_CTRL   8'h00
`define OFS_STBY_CTRL  8'h04
`define OFS_VEC_BASE   8'h08
`define OFS_INT_MODE   8'h0C
`define OFS_EV_STATUS  8'h10
`define OFS_EV_MASK    8'h14
`define OFS_LAST_VEC   8'h18

// field positions
`define BIT_TRACE      7
`define BIT_SOFTWARE_STANDBY_SELECT       7
`define BIT_SLEEP_EXCEPTION_ENABLE      1
`define BIT_IN_RESET   8

// reset values and the trace interrupt mode
`define RST_EXT_CTRL   8'h00
`define RST_STBY_CTRL  8'h00
`define RST_VEC_BASE   32'h00000000
`define RST_INT_MODE   2'h0
`define RST_EV_MASK    7'h00
`define INT_MODE_TRACE 2'h2

// vector numbers
`define VEC_RESET      8'h00
`define VEC_ILLEGAL    8'h04
`define VEC_TRACE      8'h05
`define VEC_TRAP_BASE  8'h08
`define VEC_ADDR_ERR   8'h0C
`define VEC_SLEEP      8'h12

// codes of the instruction that just completed
`define OP_OTHER       3'h0
`define OP_RTE         3'h1
`define OP_AND_CCR_INSTR        3'h2
`define OP_ORC         3'h3
`define OP_XOR_CCR_INSTR        3'h4
`define OP_LDC         3'h5

// event bits, highest priority first
`define EV_RST         0
`define EV_ILL         1
`define EV_TRC         2
`define EV_ADR         3
`define EV_IRQ         4
`define EV_SLP         5
`define EV_TRP         6
`endif

/* File: logic/exception_priority_arbiter.v */
// Chosen here: the address map and the Wishbone slave port.
`timescale 1ns/1ns
`include "exc_consts.vh"
module exception_priority_arbiter (
    input  wire        CLK_IN,          // cpu clock
    input  wire        RESET_IN,        // async reset, high
    input  wire        CE_IN,           // clock enable
    input  wire        INIT_PIN_IN,     // chip_initialise_pin, low holds reset
    input  wire        WDT_OVF_IN,      // watchdog overflow pulse
    input  wire        BOUNDARY_IN,     // instruction or handling completes
    input  wire [2:0]  LAST_OP_IN,      // code of completing instruction
    input  wire        UNDEF_EXEC_IN,   // undefined code executed
    input  wire        ADDR_ERR_IN,     // address error detected
    input  wire        IRQ_REQ_IN,      // interrupt request level
    input  wire [7:0]  IRQ_VEC_IN,      // interrupt vector number
    input  wire        SLEEP_EXEC_IN,   // sleep instruction executed
    input  wire        TRAP_EXEC_IN,    // trap_always_instr executed
    input  wire [1:0]  TRAP_NUM_IN,     // trap number
    input  wire        WB_CYC_IN,       // wishbone cycle
    input  wire        WB_STB_IN,       // wishbone strobe
    input  wire        WB_WE_IN,        // wishbone write
    input  wire [7:0]  WB_ADR_IN,       // wishbone byte address
    input  wire [3:0]  WB_SEL_IN,       // wishbone byte lanes
    input  wire [31:0] WB_DAT_IN,       // wishbone write data
    output wire [31:0] WB_DAT_OUT,      // wishbone read data
    output wire        WB_ACK_OUT,      // wishbone ack
    output wire        ACCEPT_OUT,      // one-cycle accept strobe
    output wire [7:0]  VEC_NUM_OUT,     // accepted vector number
    output wire [31:0] VEC_ADDR_OUT,    // vector table address
    output wire        IN_RESET_OUT,    // cpu held in reset state
    output wire        IRQ_OUT          // event interrupt level
);

// -----------------------------------------------------------------
// helpers
// -----------------------------------------------------------------
// merge write data into a register by byte lane
function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer i;
    begin
        lane_merge = old_v;
        for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
                lane_merge[8*i +: 8] = new_v[8*i +: 8];
            end
        end
    end
endfunction

// table address of a vector, absolute or relative to the base
function [31:0] vec_addr;
    input [7:0]  vec;
    input        absolute;
    input [31:0] base;
    reg   [31:0] ofs;
    begin
        ofs = {22'h0, vec, 2'h0};
        vec_addr = absolute ? ofs : base + ofs;
    end
endfunction

// -----------------------------------------------------------------
// state
// -----------------------------------------------------------------
reg        pin_meta_reg;
reg        pin_sync_reg;
reg        pin_prev_reg;
reg        ill_pend_reg;
reg        adr_pend_reg;
reg        slp_pend_reg;
reg        trp_pend_reg;
reg [1:0]  trp_num_reg;
reg        rst_busy_reg;
reg [7:0]  ext_ctrl_reg;
reg [7:0]  stby_ctrl_reg;
reg [31:0] vec_base_reg;
reg [1:0]  int_mode_reg;
reg [6:0]  ev_status_reg;
reg [6:0]  ev_mask_reg;
reg        accept_reg;
reg [7:0]  vnum_reg;
reg [31:0] vaddr_reg;
reg        in_reset_reg;
reg        irq_reg;
reg        ack_reg;
reg [31:0] rdat_reg;

reg [6:0]  grant;
reg [7:0]  vnum_next;
reg        abs_next;
reg [31:0] rdat_next;

// -----------------------------------------------------------------
// request conditions
// -----------------------------------------------------------------
wire pin_rise = pin_sync_reg & ~pin_prev_reg;
wire hold     = ~pin_sync_reg;
wire ccr_op   = (LAST_OP_IN == `OP_AND_CCR_INSTR) | (LAST_OP_IN == `OP_ORC) |
                (LAST_OP_IN == `OP_XOR_CCR_INSTR) | (LAST_OP_IN == `OP_LDC);
wire skip_irq = ccr_op | rst_busy_reg;
wire trace_on = ext_ctrl_reg[`BIT_TRACE] &
                (int_mode_reg == `INT_MODE_TRACE);
wire slp_ok   = ~stby_ctrl_reg[`BIT_SOFTWARE_STANDBY_SELECT] & stby_ctrl_reg[`BIT_SLEEP_EXCEPTION_ENABLE];

// reset wins its own cycle whenever the pin is not holding reset, so it never needs to wait
wire r_rst = pin_rise | WDT_OVF_IN;
wire r_ill = ill_pend_reg | UNDEF_EXEC_IN;
wire r_trc = BOUNDARY_IN & trace_on & (LAST_OP_IN != `OP_RTE);
wire adr_any = adr_pend_reg | ADDR_ERR_IN;
wire r_adr = BOUNDARY_IN & adr_any;
wire r_irq = BOUNDARY_IN & IRQ_REQ_IN & ~skip_irq;
wire r_slp = slp_pend_reg | (SLEEP_EXEC_IN & slp_ok);
wire r_trp = trp_pend_reg | TRAP_EXEC_IN;
wire [1:0] trp_num = TRAP_EXEC_IN ? TRAP_NUM_IN : trp_num_reg;

// -----------------------------------------------------------------
// priority selection, one request per cycle
// -----------------------------------------------------------------
always @* begin
    grant = 7'h00;
    if (!hold) begin
        if (r_rst) begin
            grant[`EV_RST] = 1'b1;
        end else if (r_ill) begin
            grant[`EV_ILL] = 1'b1;
        end else if (r_trc) begin
            grant[`EV_TRC] = 1'b1;
        end else if (r_adr) begin
            grant[`EV_ADR] = 1'b1;
        end else if (r_irq) begin
            grant[`EV_IRQ] = 1'b1;
        end else if (r_slp) begin
            grant[`EV_SLP] = 1'b1;
        end else if (r_trp) begin
            grant[`EV_TRP] = 1'b1;
        end
    end
end

// vector number and addressing of the granted request
always @* begin
    vnum_next = `VEC_RESET;
    abs_next  = 1'b0;
    case (1'b1)
        grant[`EV_RST]: begin
            vnum_next = `VEC_RESET;
            abs_next  = 1'b1;
        end
        grant[`EV_ILL]: vnum_next = `VEC_ILLEGAL;
        grant[`EV_TRC]: vnum_next = `VEC_TRACE;
        grant[`EV_ADR]: begin
            vnum_next = `VEC_ADDR_ERR;
            abs_next  = 1'b1;
        end
        grant[`EV_IRQ]: vnum_next = IRQ_VEC_IN;
        grant[`EV_SLP]: vnum_next = `VEC_SLEEP;
        grant[`EV_TRP]: vnum_next = `VEC_TRAP_BASE | {6'h00, trp_num};
        default:        vnum_next = `VEC_RESET;
    endcase
end

// -----------------------------------------------------------------
// initialise pin synchroniser and edge detector
// -----------------------------------------------------------------
always @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
        pin_meta_reg <= 1'b0;
        pin_sync_reg <= 1'b0;
        pin_prev_reg <= 1'b0;
    end else if (CE_IN) begin
        pin_meta_reg <= INIT_PIN_IN;
        pin_sync_reg <= pin_meta_reg;
        pin_prev_reg <= pin_sync_reg;
    end
end

// -----------------------------------------------------------------
// pending requests, kept until granted or cleared while held in reset
// -----------------------------------------------------------------
always @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
        ill_pend_reg <= 1'b0;
        adr_pend_reg <= 1'b0;
        slp_pend_reg <= 1'b0;
        trp_pend_reg <= 1'b0;
        trp_num_reg  <= 2'h0;
        rst_busy_reg <= 1'b0;
    end else if (CE_IN) begin
        if (hold) begin
            ill_pend_reg <= 1'b0;
            adr_pend_reg <= 1'b0;
            slp_pend_reg <= 1'b0;
            trp_pend_reg <= 1'b0;
            rst_busy_reg <= 1'b0;
        end else begin
            ill_pend_reg <= r_ill & ~grant[`EV_ILL];
            adr_pend_reg <= adr_any & ~grant[`EV_ADR];
            slp_pend_reg <= r_slp & ~grant[`EV_SLP];
            trp_pend_reg <= r_trp & ~grant[`EV_TRP];
            trp_num_reg  <= trp_num;
            if (grant[`EV_RST]) begin
                rst_busy_reg <= 1'b1;
            end else if (BOUNDARY_IN) begin
                rst_busy_reg <= 1'b0;
            end
        end
    end
end

// -----------------------------------------------------------------
// accept strobe and vector outputs
// -----------------------------------------------------------------
always @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
        accept_reg   <= 1'b0;
        vnum_reg     <= `VEC_RESET;
        vaddr_reg    <= 32'h00000000;
        in_reset_reg <= 1'b1;
    end else if (CE_IN) begin
        accept_reg   <= |grant;
        in_reset_reg <= hold;
        if (|grant) begin
            vnum_reg  <= vnum_next;
            vaddr_reg <= vec_addr(vnum_next, abs_next, vec_base_reg);
        end
    end
end

// -----------------------------------------------------------------
// wishbone slave, one wait state then ack
// -----------------------------------------------------------------
wire wb_hit = WB_CYC_IN & WB_STB_IN & ~ack_reg;
wire wb_wr  = wb_hit & WB_WE_IN;
wire wb_rd  = wb_hit & ~WB_WE_IN;
wire st_clr = wb_rd & (WB_ADR_IN[7:2] == `OFS_EV_STATUS >> 2);

// read data mux, unmapped reads as zero
always @* begin
    rdat_next = 32'h00000000;
    case (WB_ADR_IN[7:2])
        `OFS_EXT_CTRL  >> 2: rdat_next = {24'h000000, ext_ctrl_reg};
        `OFS_STBY_CTRL >> 2: rdat_next = {24'h000000, stby_ctrl_reg};
        `OFS_VEC_BASE  >> 2: rdat_next = vec_base_reg;
        `OFS_INT_MODE  >> 2: rdat_next = {30'h0, int_mode_reg};
        `OFS_EV_STATUS >> 2: rdat_next = {25'h0, ev_status_reg};
        `OFS_EV_MASK   >> 2: rdat_next = {25'h0, ev_mask_reg};
        `OFS_LAST_VEC  >> 2: rdat_next = {23'h0, in_reset_reg, vnum_reg};
        default:             rdat_next = 32'h00000000;
    endcase
end

// register writes and bus answer
always @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
        ext_ctrl_reg  <= `RST_EXT_CTRL;
        stby_ctrl_reg <= `RST_STBY_CTRL;
        vec_base_reg  <= `RST_VEC_BASE;
        int_mode_reg  <= `RST_INT_MODE;
        ev_mask_reg   <= `RST_EV_MASK;
        ack_reg       <= 1'b0;
        rdat_reg      <= 32'h00000000;
    end else if (CE_IN) begin
        ack_reg <= wb_hit;
        if (wb_rd) begin
            rdat_reg <= rdat_next;
        end
        if (wb_wr && WB_SEL_IN[0]) begin
            case (WB_ADR_IN[7:2])
                `OFS_EXT_CTRL  >> 2: ext_ctrl_reg  <= WB_DAT_IN[7:0];
                `OFS_STBY_CTRL >> 2: stby_ctrl_reg <= WB_DAT_IN[7:0];
                `OFS_INT_MODE  >> 2: int_mode_reg  <= WB_DAT_IN[1:0];
                `OFS_EV_MASK   >> 2: ev_mask_reg   <= WB_DAT_IN[6:0];
                default: ;
            endcase
        end
        if (wb_wr && WB_ADR_IN[7:2] == `OFS_VEC_BASE >> 2) begin
            vec_base_reg <= lane_merge(vec_base_reg, WB_DAT_IN, WB_SEL_IN);
        end
    end
end

// -----------------------------------------------------------------
// sticky event status, read clears, new events win
// -----------------------------------------------------------------
always @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
        ev_status_reg <= 7'h00;
        irq_reg       <= 1'b0;
    end else if (CE_IN) begin
        ev_status_reg <= (ev_status_reg & ~{7{st_clr}}) | grant;
        irq_reg       <= |(((ev_status_reg & ~{7{st_clr}}) | grant) & ev_mask_reg);
    end
end

assign WB_DAT_OUT   = rdat_reg;
assign WB_ACK_OUT   = ack_reg;
assign ACCEPT_OUT   = accept_reg;
assign VEC_NUM_OUT  = vnum_reg;
assign VEC_ADDR_OUT = vaddr_reg;
assign IN_RESET_OUT = in_reset_reg;
assign IRQ_OUT      = irq_reg;

endmodule // exception_priority_arbiter

/* File: verification/exception_priority_arbiter_checker.sv */
`timescale 1ns/1ns
`include "exc_consts.vh"
module exception_priority_arbiter_checker (
    input wire        CLK_IN,        // cpu clock
    input wire        RESET_IN,      // async reset
    input wire        CE_IN,         // clock enable
    input wire        WDT_OVF_IN,    // watchdog pulse
    input wire        BOUNDARY_IN,   // boundary pulse
    input wire [2:0]  LAST_OP_IN,    // completing op
    input wire        UNDEF_EXEC_IN, // undefined code
    input wire        ADDR_ERR_IN,   // address error
    input wire        IRQ_REQ_IN,    // irq level
    input wire [7:0]  IRQ_VEC_IN,    // irq vector
    input wire        SLEEP_EXEC_IN, // sleep pulse
    input wire        TRAP_EXEC_IN,  // trap pulse
    input wire [1:0]  TRAP_NUM_IN,   // trap number
    input wire        ACCEPT_OUT,    // accept strobe
    input wire [7:0]  VEC_NUM_OUT,   // vector number
    input wire [31:0] VEC_ADDR_OUT,  // vector address
    input wire        IN_RESET_OUT   // reset state
);
    default clocking cb @(posedge CLK_IN);
    endclocking
    // a frozen block answers nothing, so checks pause with the enable
    default disable iff (RESET_IN || !CE_IN);
    // ----------------------------------------
    // request shapes
    // ----------------------------------------
    sequence s_no_higher;
        !WDT_OVF_IN && !IN_RESET_OUT;
    endsequence
    sequence s_lone_trap;
        TRAP_EXEC_IN && !UNDEF_EXEC_IN && !SLEEP_EXEC_IN && !BOUNDARY_IN ##0 s_no_higher;
    endsequence
    sequence s_leave_reset;
        $fell(IN_RESET_OUT);
    endsequence
    // ----------------------------------------
    // acceptance checks
    // ----------------------------------------
    a_trap_vector: assert property (s_lone_trap |=> ACCEPT_OUT &&
        VEC_NUM_OUT == `VEC_TRAP_BASE + {6'h00, $past(TRAP_NUM_IN)})
        else $error("trap not taken with its vector");
    a_illegal_now: assert property (UNDEF_EXEC_IN ##0 s_no_higher |=>
        ACCEPT_OUT && VEC_NUM_OUT == `VEC_ILLEGAL) else $error("illegal code not taken");
    a_wdt_reset: assert property (WDT_OVF_IN && !IN_RESET_OUT |=> ACCEPT_OUT &&
        VEC_NUM_OUT == `VEC_RESET && VEC_ADDR_OUT == 32'h00000000)
        else $error("watchdog reset not taken");
    a_hold_quiet: assert property (IN_RESET_OUT |-> !ACCEPT_OUT)
        else $error("accept while held in reset");
    a_reset_start: assert property (s_leave_reset |-> ACCEPT_OUT &&
        VEC_NUM_OUT == `VEC_RESET) else $error("reset handling missing on release");
    a_irq_skip_ccr: assert property (BOUNDARY_IN && IRQ_REQ_IN && LAST_OP_IN >= `OP_AND_CCR_INSTR
        && LAST_OP_IN <= `OP_LDC |=> !(ACCEPT_OUT && VEC_NUM_OUT == $past(IRQ_VEC_IN)))
        else $error("interrupt taken after ccr op");
    a_addr_waits: assert property (ADDR_ERR_IN && !BOUNDARY_IN |=>
        !(ACCEPT_OUT && VEC_NUM_OUT == `VEC_ADDR_ERR)) else $error("address error too early");
    a_abs_address: assert property (ACCEPT_OUT && (VEC_NUM_OUT == `VEC_ADDR_ERR ||
        VEC_NUM_OUT == `VEC_RESET) |-> VEC_ADDR_OUT == {22'h0, VEC_NUM_OUT, 2'h0})
        else $error("absolute vector address wrong");
endmodule // exception_priority_arbiter_checker

bind exception_priority_arbiter exception_priority_arbiter_checker chk (
    .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .CE_IN(CE_IN), .WDT_OVF_IN(WDT_OVF_IN),
    .BOUNDARY_IN(BOUNDARY_IN),
    .LAST_OP_IN(LAST_OP_IN), .UNDEF_EXEC_IN(UNDEF_EXEC_IN), .ADDR_ERR_IN(ADDR_ERR_IN),
    .IRQ_REQ_IN(IRQ_REQ_IN), .IRQ_VEC_IN(IRQ_VEC_IN), .SLEEP_EXEC_IN(SLEEP_EXEC_IN),
    .TRAP_EXEC_IN(TRAP_EXEC_IN), .TRAP_NUM_IN(TRAP_NUM_IN), .ACCEPT_OUT(ACCEPT_OUT),
    .VEC_NUM_OUT(VEC_NUM_OUT), .VEC_ADDR_OUT(VEC_ADDR_OUT), .IN_RESET_OUT(IN_RESET_OUT));

/* File: verification/sequencer_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// instruction sequencer stand-in
// ----------------------------------------
module sequencer_model (
    input  wire       clk_in,       // cpu clock
    output reg        boundary_out, // instruction end
    output reg  [2:0] last_op_out,  // completing op
    output reg        undef_out,    // undefined code
    output reg        addr_err_out, // address error
    output reg        sleep_out,    // sleep executed
    output reg        trap_out,     // trap executed
    output reg  [1:0] trap_num_out  // trap number
);
    // quiet lines at time zero
    initial begin
        {trap_out, sleep_out, addr_err_out, undef_out, boundary_out} = 5'h00;
        last_op_out = 3'h7;
        trap_num_out = 2'h0;
    end
    // one-cycle event pulse; codes are scrambled once they mean nothing
    task automatic step(input logic [4:0] ev, input logic [2:0] op, input logic [1:0] num);
        {trap_out, sleep_out, addr_err_out, undef_out, boundary_out} <= ev;
        last_op_out <= op;
        trap_num_out <= num;
        @(posedge clk_in);
        {trap_out, sleep_out, addr_err_out, undef_out, boundary_out} <= 5'h00;
        last_op_out <= ~op;
        trap_num_out <= ~num;
    endtask
endmodule // sequencer_model

/* File: verification/exception_priority_arbiter_tb.sv */
`timescale 1ns/1ns
`include "exc_consts.vh"
module exception_priority_arbiter_tb;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam logic [31:0] VB   = 32'h00001000; // vector base in use
    localparam logic [7:0]  IVEC = 8'h40;        // interrupt vector
    logic        clk = 1'b0, rst = 1'b1, pin = 1'b1, wdt = 1'b0, irq = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ce = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h00000000, rd;
    logic [31:0] sbv [3] = '{32'h00000082, 32'h00000000, 32'h00000080};
    wire         bnd, undf, aerr, slp, trp, ack, acc, in_rst, irq_o;
    wire  [2:0]  op;
    wire  [1:0]  tnum;
    wire  [7:0]  vnum;
    wire  [31:0] rdat, vaddr;
    int          mismatches = 0, tests_run = 0;

    // 25 MHz cpu clock
    always #20 clk = ~clk;

    sequencer_model seq (.clk_in(clk), .boundary_out(bnd), .last_op_out(op),
        .undef_out(undf), .addr_err_out(aerr), .sleep_out(slp), .trap_out(trp),
        .trap_num_out(tnum));
    exception_priority_arbiter DUT (.CLK_IN(clk), .RESET_IN(rst), .CE_IN(ce),
        .INIT_PIN_IN(pin), .WDT_OVF_IN(wdt), .BOUNDARY_IN(bnd), .LAST_OP_IN(op),
        .UNDEF_EXEC_IN(undf), .ADDR_ERR_IN(aerr), .IRQ_REQ_IN(irq), .IRQ_VEC_IN(IVEC),
        .SLEEP_EXEC_IN(slp), .TRAP_EXEC_IN(trp), .TRAP_NUM_IN(tnum), .WB_CYC_IN(cyc),
        .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wdat),
        .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .ACCEPT_OUT(acc), .VEC_NUM_OUT(vnum),
        .VEC_ADDR_OUT(vaddr), .IN_RESET_OUT(in_rst), .IRQ_OUT(irq_o));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("Counts: %0d checks, %0d mismatches", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // one classic bus cycle, released only after ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        if (n == 20) begin
            mismatches++;
            wrap_up();
        end
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, a, 32'h00000000, r);
        chk(r, e);
    endtask
    // strobe and vector in the cycle after the request
    task automatic exp_acc(input logic a, input logic [7:0] v, input logic [31:0] ad);
        @(posedge clk);
        chk({31'h0, acc}, {31'h0, a});
        if (a) begin
            chk({24'h0, vnum}, {24'h0, v});
            chk(vaddr, ad);
        end
    endtask
    task automatic wait_rst();
        for (int n = 0; n < 12 && acc !== 1'b1; n++) @(posedge clk);
        chk({31'h0, acc}, 32'h1);
        if (acc !== 1'b1) wrap_up();
        chk({24'h0, vnum}, 32'h0);
        chk(vaddr, 32'h0);
        chk({31'h0, in_rst}, 32'h0);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        wait_rst();
        rdchk(`OFS_EV_STATUS, 32'h01);
        rdchk(`OFS_EV_MASK, 32'h0);
        rdchk(8'h1C, 32'h0);
        wb(1'b1, `OFS_VEC_BASE, VB, rd);
        wb(1'b1, `OFS_STBY_CTRL, 32'h02, rd);
        $display("Test reset finished");
        irq <= 1'b1;
        seq.step(5'h01, `OP_OTHER, 2'h0);
        exp_acc(1'b0, 8'h00, 32'h0);
        for (int k = `OP_AND_CCR_INSTR; k <= `OP_LDC; k++) begin
            seq.step(5'h01, `OP_OTHER, 2'h0);
            exp_acc(1'b1, IVEC, VB + 32'h100);
            seq.step(5'h01, k[2:0], 2'h0);
            exp_acc(1'b0, 8'h00, 32'h0);
        end
        irq <= 1'b0;
        seq.step(5'h04, `OP_OTHER, 2'h0);
        exp_acc(1'b0, 8'h00, 32'h0);
        irq <= 1'b1;
        seq.step(5'h01, `OP_OTHER, 2'h0);
        exp_acc(1'b1, `VEC_ADDR_ERR, 32'h30);
        seq.step(5'h01, `OP_OTHER, 2'h0);
        exp_acc(1'b1, IVEC, VB + 32'h100);
        irq <= 1'b0;
        seq.step(5'h12, `OP_OTHER, 2'h3);
        exp_acc(1'b1, `VEC_ILLEGAL, VB + 32'h10);
        exp_acc(1'b1, 8'h0B, VB + 32'h2C);
        seq.step(5'h18, `OP_OTHER, 2'h0);
        exp_acc(1'b1, `VEC_SLEEP, VB + 32'h48);
        exp_acc(1'b1, `VEC_TRAP_BASE, VB + 32'h20);
        $display("Test priority finished");
        foreach (sbv[i]) begin
            wb(1'b1, `OFS_STBY_CTRL, sbv[i], rd);
            seq.step(5'h08, `OP_OTHER, 2'h0);
            exp_acc(1'b0, 8'h00, 32'h0);
        end
        wb(1'b1, `OFS_EXT_CTRL, 32'h80, rd);
        seq.step(5'h01, `OP_OTHER, 2'h0);
        exp_acc(1'b0, 8'h00, 32'h0);
        wb(1'b1, `OFS_INT_MODE, 32'h02, rd);
        seq.step(5'h01, `OP_RTE, 2'h0);
        exp_acc(1'b0, 8'h00, 32'h0);
        seq.step(5'h01, `OP_OTHER, 2'h0);
        exp_acc(1'b1, `VEC_TRACE, VB + 32'h14);
        wb(1'b1, `OFS_EXT_CTRL, 32'h00, rd);
        $display("Test gating finished");
        wdt <= 1'b1;
        @(posedge clk);
        wdt <= 1'b0;
        exp_acc(1'b1, `VEC_RESET, 32'h0);
        pin <= 1'b0;
        repeat (4) @(posedge clk);
        chk({31'h0, in_rst}, 32'h1);
        seq.step(5'h10, `OP_OTHER, 2'h1);
        exp_acc(1'b0, 8'h00, 32'h0);
        pin <= 1'b1;
        wait_rst();
        rdchk(`OFS_EV_STATUS, 32'h7F);
        wb(1'b1, `OFS_EV_MASK, 32'h40, rd);
        seq.step(5'h10, `OP_OTHER, 2'h1);
        exp_acc(1'b1, 8'h09, VB + 32'h24);
        @(posedge clk);
        chk({31'h0, irq_o}, 32'h1);
        rdchk(`OFS_EV_STATUS, 32'h40);
        @(posedge clk);
        chk({31'h0, irq_o}, 32'h0);
        wb(1'b1, `OFS_EV_MASK, 32'h20, rd);
        seq.step(5'h10, `OP_OTHER, 2'h2);
        exp_acc(1'b1, 8'h0A, VB + 32'h28);
        @(posedge clk);
        chk({31'h0, irq_o}, 32'h0);
        // a trap pulse while the enable is low is lost
        ce <= 1'b0;
        seq.step(5'h10, `OP_OTHER, 2'h1);
        exp_acc(1'b0, 8'h00, 32'h0);
        ce <= 1'b1;
        rdchk(`OFS_LAST_VEC, 32'h0000000A);
        rdchk(`OFS_VEC_BASE, VB);
        rdchk(`OFS_INT_MODE, 32'h00000002);
        $display("Test events finished");
        wrap_up();
    end
endmodule // exception_priority_arbiter_tb
